// ==== src/rurw_pkg.sv ====
/*
  shared constants for the remote upgrade reconfiguration block:
  register offsets, field positions, reset values and the state type.
  assumes a 32-bit apb slave with byte addresses on a 12-bit paddr.
*/
package rurw_pkg;
  // field widths
  localparam int ADDR_W = 24;
  localparam int WDOG_SET_W = 12;
  localparam int WDOG_LOW_W = 17;
  localparam int WDOG_CNT_W = 29;
  localparam int REC_W = 31;
  localparam int OPT_W = 15;
  localparam int CAUSE_W = 5;
  localparam int STAT_W = 7;
  // register byte offsets
  localparam logic [11:0] OFS_ADDR = 12'h000;
  localparam logic [11:0] OFS_OPT = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam logic [11:0] OFS_PRIOR1 = 12'h00c;
  localparam logic [11:0] OFS_PRIOR2 = 12'h010;
  // option word: early done, internal osc, watchdog enable, setting
  localparam int OPT_EARLY = 0;
  localparam int OPT_OSC = 1;
  localparam int OPT_WDEN = 2;
  localparam int OPT_WDOG_LSB = 3;
  // prior record fields
  localparam int REC_CAUSE_LSB = 26;
  localparam int REC_STATE_LSB = 24;
  // cause bits, highest wins
  localparam int CAUSE_EXT = 4;
  localparam int CAUSE_CRC = 3;
  localparam int CAUSE_STAT = 2;
  localparam int CAUSE_WDOG = 1;
  localparam int CAUSE_CORE = 0;
  // status word: state in low bits, last cause above it
  localparam int STAT_CAUSE_LSB = 2;
  // reset values and the misuse marker (illegal one-hot cause)
  localparam logic [ADDR_W-1:0] CTL_ADDR_RST = 24'h000000;
  localparam logic [OPT_W-1:0] CTL_OPT_RST = 15'h0000;
  localparam logic [REC_W-1:0] PRIOR_INVALID = 31'h7fffffff;
  // oscillator tick derived from the core clock
  localparam int CLK_PERIOD_PS = 5000;
  localparam int OSC_PERIOD_PS = 100000;
  localparam int OSC_DIV = OSC_PERIOD_PS / CLK_PERIOD_PS;
  typedef enum logic [1:0] {
    ST_FACT_CFG,
    ST_FACTORY,
    ST_APP_CFG,
    ST_APP_USER
  } rurw_state_e;
endpackage

// ==== src/rurw_wdog.sv ====
/*
  29-bit user watchdog down-counter, stepped by an oscillator tick.
  assumes the caller drops enable outside application user mode.
*/
`timescale 1ns/1ps
module rurw_wdog #(
  parameter int CNT_W = 29,
  parameter int SET_W = 12
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic enable,
  input wire logic reload,
  input wire logic tick,
  input wire logic [SET_W-1:0] setting,
  output logic expired,
  output logic [CNT_W-1:0] count
);
  logic [CNT_W-1:0] load_val;

  // setting fills the top bits, low bits start from zero
  assign load_val = {setting, {(CNT_W-SET_W){1'b0}}}; // [R22] [R14]

  // held at the load value while disabled, so it starts fresh
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      count <= '0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (!enable || reload) begin
        count <= load_val; // [R13] [R19]
      end else if (tick) begin
        if (count == '0) begin
          expired <= 1'b1; // [R18]
        end else begin
          count <= count - 1'b1; // [R15]
        end
      end
    end
  end

  a_wdog_expiry: assert property (@(posedge core_clk) // [R18]
    disable iff (reset)
    expired |-> $past(count) == '0 && $past(tick) && $past(enable))
    else $error("watchdog expired without a zero count");
endmodule // rurw_wdog

// ==== src/rurw_top.sv ====
/*
  remote upgrade reconfiguration controller with user watchdog:
  update/control registers, status, two prior-state records, apb slave.
  assumes apb master on core_clk and synchronous event inputs;
  config_done pulses when a configuration cycle reaches user mode.
*/
`timescale 1ns/1ps
// Behaviour
// [R1] prior record bits 30:26 hold one-hot cause of leaving the app
// [R2] simultaneous causes: only the highest bit position is recorded
// [R3] record bits 25:24 hold state at the reconfiguration event
// [R4] record bits 23:0 hold the boot address of that application
// [R5] second record has same layout, one application further back
// [R6] reading a record before it exists returns a marker value
// [R7] update/control share layout; change only in factory mode
// [R8] user logic writes next application settings into update
// [R9] request rising in factory copies update to control, loads app
// [R10] errors clear control to zero; core trigger loads update
// [R11] status records the error before factory load begins
// [R12] reads show update in factory, control in application
// [R13] watchdog is 29-bit down-counter from the control setting
// [R14] watchdog set by top 12 bits, 2^17 cycle steps
// [R15] watchdog counts oscillator ticks, not user clock
// [R16] watchdog counts only after application enters user mode
// [R17] user logic reloads watchdog before it expires
// [R18] expiry sets watchdog flag and loads factory configuration
// [R19] watchdog disabled in configuration cycles and factory mode
// [R20] falling kick edge restarts watchdog from initial count
// [R21] request low: factory loads application, application loads factory; factory here acts on the rising edge
// [R22] reload puts setting in upper bits, low 17 bits zero
module rurw_top #(
  parameter int OSC_DIV = rurw_pkg::OSC_DIV
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic logic_reconfig_request_n,
  input wire logic watchdog_kick_n,
  input wire logic external_reconfig_pin_n,
  input wire logic config_status_pin_n,
  input wire logic crc_error,
  input wire logic config_done,
  output logic [1:0] config_state,
  output logic reconfig_start,
  output logic [23:0] boot_address,
  output logic early_done_option,
  output logic internal_osc_option,
  output logic watchdog_timeout_flag
);
  localparam int AW = rurw_pkg::ADDR_W;
  localparam int OW = rurw_pkg::OPT_W;
  localparam int RW = rurw_pkg::REC_W;
  localparam int CW = rurw_pkg::CAUSE_W;

  rurw_pkg::rurw_state_e state_q;
  logic [AW-1:0] upd_addr_q;
  logic [OW-1:0] upd_opt_q;
  logic [AW-1:0] ctl_addr_q;
  logic [OW-1:0] ctl_opt_q;
  logic [rurw_pkg::STAT_W-1:0] status_q;
  logic [RW-1:0] rec1_q;
  logic [RW-1:0] rec2_q;
  logic rec1_vld_q;
  logic rec2_vld_q;
  logic req_q;
  logic kick_q;
  logic ext_q;
  logic stat_q;
  logic start_q;
  logic [31:0] prdata_q;
  logic [7:0] osc_cnt_q;
  logic osc_tick;
  logic req_rise;
  logic req_fall;
  logic kick_fall;
  logic ext_fall;
  logic stat_fall;
  logic in_factory;
  logic in_app;
  logic core_trig;
  logic err_evt;
  logic any_evt;
  logic wdog_expired;
  logic wdog_enable;
  logic [rurw_pkg::WDOG_CNT_W-1:0] wdog_count;
  logic [CW-1:0] cause;
  logic setup;
  logic access;
  logic mapped;
  logic upd_wr;

  // one-hot pick, highest position wins on a tie
  function automatic logic [CW-1:0] pick_cause(
    input logic [CW-1:0] raw
  );
    logic [CW-1:0] r;
    r = '0;
    for (int i = 0; i < CW; i++) begin
      if (raw[i]) begin
        r = '0;
        r[i] = 1'b1;
      end
    end
    return r;
  endfunction

  // true when the offset names a register
  function automatic logic is_mapped(input logic [11:0] a);
    return a == rurw_pkg::OFS_ADDR || a == rurw_pkg::OFS_OPT ||
      a == rurw_pkg::OFS_STATUS || a == rurw_pkg::OFS_PRIOR1 ||
      a == rurw_pkg::OFS_PRIOR2;
  endfunction

  // previous levels for edge detection; inputs idle high
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      req_q <= 1'b1;
      kick_q <= 1'b1;
      ext_q <= 1'b1;
      stat_q <= 1'b1;
    end else begin
      req_q <= logic_reconfig_request_n;
      kick_q <= watchdog_kick_n;
      ext_q <= external_reconfig_pin_n;
      stat_q <= config_status_pin_n;
    end
  end

  assign req_rise = !req_q && logic_reconfig_request_n;
  assign req_fall = req_q && !logic_reconfig_request_n;
  assign kick_fall = kick_q && !watchdog_kick_n;
  assign ext_fall = ext_q && !external_reconfig_pin_n;
  assign stat_fall = stat_q && !config_status_pin_n;
  assign in_factory = state_q == rurw_pkg::ST_FACT_CFG ||
    state_q == rurw_pkg::ST_FACTORY;
  assign in_app = !in_factory;

  // factory commits on the rising edge, so the update is settled
  assign core_trig = (state_q == rurw_pkg::ST_FACTORY) ? req_rise :
    (in_app && req_fall); // [R9] [R21]
  assign err_evt = ext_fall || crc_error || stat_fall || wdog_expired;
  assign any_evt = err_evt || core_trig;
  assign cause = pick_cause({ext_fall, crc_error, stat_fall,
    wdog_expired, core_trig}); // [R2]

  // oscillator stand-in: one tick per oscillator period
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      osc_cnt_q <= '0;
    end else if (osc_cnt_q == 8'(OSC_DIV - 1)) begin
      osc_cnt_q <= '0;
    end else begin
      osc_cnt_q <= osc_cnt_q + 8'h01;
    end
  end
  assign osc_tick = osc_cnt_q == 8'(OSC_DIV - 1); // [R15]

  // master state: errors and app-side requests go to factory
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_q <= rurw_pkg::ST_FACT_CFG;
    end else if (err_evt) begin
      state_q <= rurw_pkg::ST_FACT_CFG; // [R18]
    end else if (core_trig) begin
      state_q <= in_factory ? rurw_pkg::ST_APP_CFG :
        rurw_pkg::ST_FACT_CFG; // [R21]
    end else if (config_done) begin
      unique case (state_q)
        rurw_pkg::ST_FACT_CFG: state_q <= rurw_pkg::ST_FACTORY;
        rurw_pkg::ST_APP_CFG: state_q <= rurw_pkg::ST_APP_USER;
        rurw_pkg::ST_FACTORY: state_q <= rurw_pkg::ST_FACTORY;
        rurw_pkg::ST_APP_USER: state_q <= rurw_pkg::ST_APP_USER;
      endcase
    end
  end

  // update register: software writes only in factory user mode
  assign upd_wr = access && pwrite && state_q == rurw_pkg::ST_FACTORY;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      upd_addr_q <= rurw_pkg::CTL_ADDR_RST;
      upd_opt_q <= rurw_pkg::CTL_OPT_RST;
    end else if (upd_wr) begin
      if (paddr == rurw_pkg::OFS_ADDR) begin
        upd_addr_q <= pwdata[AW-1:0]; // [R7] [R8]
      end
      if (paddr == rurw_pkg::OFS_OPT) begin
        upd_opt_q <= pwdata[OW-1:0]; // [R7] [R8]
      end
    end
  end

  // control register: written by the state machine alone
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ctl_addr_q <= rurw_pkg::CTL_ADDR_RST;
      ctl_opt_q <= rurw_pkg::CTL_OPT_RST;
    end else if (err_evt) begin
      ctl_addr_q <= '0; // [R10]
      ctl_opt_q <= '0; // [R10]
    end else if (core_trig) begin
      ctl_addr_q <= upd_addr_q; // [R9] [R10]
      ctl_opt_q <= upd_opt_q; // [R9] [R10]
    end
  end

  // status catches the cause in the event cycle, before factory load
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      status_q <= '0;
    end else begin
      status_q[1:0] <= state_q;
      if (any_evt) begin
        status_q[rurw_pkg::STAT_CAUSE_LSB +: CW] <= cause; // [R11] [R18]
      end
    end
  end

  // records shift only when an application is left
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rec1_q <= '0;
      rec2_q <= '0;
      rec1_vld_q <= 1'b0;
      rec2_vld_q <= 1'b0;
    end else if (any_evt && in_app) begin
      rec2_q <= rec1_q; // [R5]
      rec2_vld_q <= rec1_vld_q; // [R5]
      rec1_q <= {cause, state_q, ctl_addr_q}; // [R1] [R3] [R4]
      rec1_vld_q <= 1'b1;
    end
  end

  // one-cycle start pulse toward the configuration engine
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      start_q <= 1'b0;
    end else begin
      start_q <= any_evt;
    end
  end

  // watchdog runs only in application user mode with enable set
  assign wdog_enable = state_q == rurw_pkg::ST_APP_USER &&
    ctl_opt_q[rurw_pkg::OPT_WDEN]; // [R16] [R19]

  rurw_wdog #(
    .CNT_W(rurw_pkg::WDOG_CNT_W),
    .SET_W(rurw_pkg::WDOG_SET_W)
  ) u_wdog (
    .core_clk(core_clk),
    .reset(reset),
    .enable(wdog_enable),
    .reload(kick_fall), // [R20] [R17]
    .tick(osc_tick),
    .setting(ctl_opt_q[rurw_pkg::OPT_WDOG_LSB +: rurw_pkg::WDOG_SET_W]),
    .expired(wdog_expired),
    .count(wdog_count)
  );

  // apb: read data is captured in setup so it comes from a flop
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign mapped = is_mapped(paddr);
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      prdata_q <= '0;
    end else if (setup && !pwrite) begin
      prdata_q <= '0;
      unique case (1'b1)
        paddr == rurw_pkg::OFS_ADDR:
          prdata_q[AW-1:0] <= in_factory ? upd_addr_q : ctl_addr_q; // [R12]
        paddr == rurw_pkg::OFS_OPT:
          prdata_q[OW-1:0] <= in_factory ? upd_opt_q : ctl_opt_q; // [R12]
        paddr == rurw_pkg::OFS_STATUS:
          prdata_q[rurw_pkg::STAT_W-1:0] <= status_q;
        paddr == rurw_pkg::OFS_PRIOR1:
          prdata_q[RW-1:0] <= rec1_vld_q ? rec1_q :
            rurw_pkg::PRIOR_INVALID; // [R6]
        paddr == rurw_pkg::OFS_PRIOR2:
          prdata_q[RW-1:0] <= rec2_vld_q ? rec2_q :
            rurw_pkg::PRIOR_INVALID; // [R6]
        default: prdata_q <= '0;
      endcase
    end
  end

  // zero wait states; unmapped offsets answer with an error
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata = prdata_q;
  assign config_state = status_q[1:0];
  assign reconfig_start = start_q;
  assign boot_address = ctl_addr_q;
  assign early_done_option = ctl_opt_q[rurw_pkg::OPT_EARLY];
  assign internal_osc_option = ctl_opt_q[rurw_pkg::OPT_OSC];
  assign watchdog_timeout_flag =
    status_q[rurw_pkg::STAT_CAUSE_LSB + rurw_pkg::CAUSE_WDOG]; // [R18]

  a_rec_onehot: assert property (@(posedge core_clk) // [R1]
    disable iff (reset) (any_evt && in_app) |=> $onehot(rec1_q[30:26]))
    else $error("prior cause not one-hot");

  a_cause_prio: assert property (@(posedge core_clk) // [R2]
    disable iff (reset) ext_fall |=> status_q[6] && status_q[5:2] == 4'h0)
    else $error("external pin lost priority");

  a_rec_state: assert property (@(posedge core_clk) disable iff (reset) // [R3]
    (any_evt && in_app) |=> rec1_q[25:24] == $past(state_q))
    else $error("prior state field wrong");

  a_rec_addr: assert property (@(posedge core_clk) disable iff (reset) // [R4]
    (any_evt && in_app) |=> rec1_q[23:0] == $past(ctl_addr_q))
    else $error("prior address field wrong");

  a_rec_shift: assert property (@(posedge core_clk) disable iff (reset) // [R5]
    (any_evt && in_app) |=> rec2_q == $past(rec1_q))
    else $error("second record not shifted");

  a_early_read: assert property (@(posedge core_clk) // [R6]
    disable iff (reset)
    (setup && !pwrite && paddr == rurw_pkg::OFS_PRIOR1 && !rec1_vld_q)
    |=> prdata_q[30:0] == rurw_pkg::PRIOR_INVALID)
    else $error("invalid capture not flagged");

  a_upd_locked: assert property (@(posedge core_clk) // [R7]
    disable iff (reset) (access && pwrite && state_q != rurw_pkg::ST_FACTORY)
    |=> $stable(upd_addr_q) && $stable(upd_opt_q))
    else $error("update written outside factory");

  a_core_copy: assert property (@(posedge core_clk) disable iff (reset) // [R9]
    (core_trig && !err_evt) |=> ctl_addr_q == $past(upd_addr_q)
    && ctl_opt_q == $past(upd_opt_q))
    else $error("control did not take update");

  a_err_clear: assert property (@(posedge core_clk) // [R10]
    disable iff (reset) err_evt |=> ctl_addr_q == '0 && ctl_opt_q == '0
    && state_q == rurw_pkg::ST_FACT_CFG)
    else $error("control not cleared on error");

  a_wdog_off: assert property (@(posedge core_clk) disable iff (reset) // [R19]
    (state_q != rurw_pkg::ST_APP_USER) |=> !wdog_expired)
    else $error("watchdog fired outside user mode");

  a_kick_reload: assert property (@(posedge core_clk) // [R20]
    disable iff (reset) (kick_fall && wdog_enable) |=> wdog_count ==
    {$past(ctl_opt_q[14:3]), 17'h00000})
    else $error("kick did not reload watchdog");
endmodule // rurw_top

// ==== verif/rurw_user_model.sv ====
/*
  behavioural model of the user logic in the programmable array that
  drives the reconfiguration request and the watchdog kick.
  assumes the bench states its intent on want_reconfig and want_kick,
  changed right after a rising edge of core_clk.
*/
`timescale 1ns/1ps
module rurw_user_model (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic want_reconfig,
  input wire logic want_kick,
  output logic logic_reconfig_request_n,
  output logic watchdog_kick_n
);
  // request held low for as long as the user asks; idles high so that
  // the release of reset never shows a false falling edge
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      logic_reconfig_request_n <= 1'b1;
    end else begin
      logic_reconfig_request_n <= ~want_reconfig;
    end
  end

  // kick follows the user's periodic reload; one registered stage,
  // like any flop in the array fabric
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      watchdog_kick_n <= 1'b1;
    end else begin
      watchdog_kick_n <= ~want_kick;
    end
  end
endmodule // rurw_user_model

// ==== verif/test_remote_upgrade_reconfig_watchdog.sv ====
/*
  self-checking bench for the remote upgrade controller: apb register
  access, factory/application hand-over, watchdog expiry and causes.
  assumes rurw_top with a short oscillator divider and the user model.
*/
`timescale 1ns/1ps
module test_remote_upgrade_reconfig_watchdog;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic req_n;
  logic kick_n;
  logic ext_n = 1'b1;
  logic stat_n = 1'b1;
  logic crc_error = 1'b0;
  logic config_done = 1'b0;
  logic [1:0] config_state;
  logic reconfig_start;
  logic [23:0] boot_address;
  logic early_done_option;
  logic internal_osc_option;
  logic watchdog_timeout_flag;
  logic want_reconfig = 1'b0;
  logic want_kick = 1'b0;
  int errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int starts = 0;

  // 200 mhz core clock
  always #2.5 core_clk = ~core_clk;

  // short divider keeps the watchdog tick every two cycles
  rurw_top #(.OSC_DIV(2)) dut_u (
    .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .logic_reconfig_request_n(req_n), .watchdog_kick_n(kick_n),
    .external_reconfig_pin_n(ext_n), .config_status_pin_n(stat_n),
    .crc_error(crc_error), .config_done(config_done),
    .config_state(config_state), .reconfig_start(reconfig_start),
    .boot_address(boot_address), .early_done_option(early_done_option),
    .internal_osc_option(internal_osc_option),
    .watchdog_timeout_flag(watchdog_timeout_flag)
  );

  rurw_user_model user_u (
    .core_clk(core_clk), .reset(reset), .want_reconfig(want_reconfig),
    .want_kick(want_kick), .logic_reconfig_request_n(req_n),
    .watchdog_kick_n(kick_n)
  );

  task finish_test();
    if (errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // cycle ceiling and a count of reconfiguration pulses
  always @(posedge core_clk) begin
    cyc++;
    if (reconfig_start === 1'b1) begin
      starts++;
    end
    if (cyc == 5000) begin
      errors++;
      finish_test();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // one apb transfer; waits on pready, then lets one idle edge pass so
  // the next call never re-drives psel in the step that released it
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wdat,
           output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wdat;
    tick(1);
    penable <= 1'b1;
    do begin
      tick(1);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    tick(1);
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask

  task rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h00000000, rd, err);
    chk(rd, exp);
  endtask

  task boot_done();
    config_done <= 1'b1;
    tick(1);
    config_done <= 1'b0;
    tick(3);
  endtask

  task req(input logic v);
    want_reconfig <= v;
    tick(4);
  endtask

  initial begin
    logic [31:0] rd;
    logic err;
    int n;
    tick(16);
    reset <= 1'b0;
    tick(1);
    rd_chk(rurw_pkg::OFS_STATUS, 32'h00000000);
    rd_chk(rurw_pkg::OFS_PRIOR1, 32'h7fffffff);
    rd_chk(rurw_pkg::OFS_PRIOR2, 32'h7fffffff);
    apb(1'b0, 12'h020, 32'h00000000, rd, err);
    chk({31'h0, err}, 32'h00000001);
    chk(rd, 32'h00000000);
    // update is locked while the factory image is still loading
    wr(rurw_pkg::OFS_ADDR, 32'h00000fff);
    rd_chk(rurw_pkg::OFS_ADDR, 32'h00000000);
    boot_done();
    chk(32'(config_state), 32'h00000001);
    wr(rurw_pkg::OFS_ADDR, 32'h00123456);
    wr(rurw_pkg::OFS_OPT, 32'h00000003);
    wr(rurw_pkg::OFS_PRIOR1, 32'h00000000);
    rd_chk(rurw_pkg::OFS_ADDR, 32'h00123456);
    rd_chk(rurw_pkg::OFS_OPT, 32'h00000003);
    rd_chk(rurw_pkg::OFS_PRIOR1, 32'h7fffffff);
    chk({8'h0, boot_address}, 32'h00000000);
    want_kick <= 1'b1;
    tick(2);
    want_kick <= 1'b0;
    req(1'b1);
    req(1'b0);
    chk({8'h0, boot_address}, 32'h00123456);
    chk({30'h0, early_done_option, internal_osc_option}, 32'h3);
    chk(32'(config_state), 32'h00000002);
    boot_done();
    rd_chk(rurw_pkg::OFS_ADDR, 32'h00123456);
    // leaving the application by request returns to factory
    req(1'b1);
    chk(32'(config_state), 32'h00000000);
    chk({8'h0, boot_address}, 32'h00123456);
    req(1'b0);
    rd_chk(rurw_pkg::OFS_PRIOR1, 32'h07123456);
    rd_chk(rurw_pkg::OFS_STATUS, 32'h00000004);
    // second application with the watchdog armed at setting zero
    boot_done();
    wr(rurw_pkg::OFS_ADDR, 32'h0000abcd);
    wr(rurw_pkg::OFS_OPT, 32'h00000004);
    req(1'b1);
    req(1'b0);
    tick(40);
    chk(32'(config_state), 32'h00000002);
    // kick lands as user mode starts, so the reload path is exercised
    want_kick <= 1'b1;
    boot_done();
    want_kick <= 1'b0;
    n = 0;
    while (config_state !== 2'h0 && n < 40) begin
      tick(1);
      n++;
    end
    tick(4);
    chk(32'(config_state), 32'h00000000);
    chk({31'h0, watchdog_timeout_flag}, 32'h00000001);
    chk({8'h0, boot_address}, 32'h00000000);
    rd_chk(rurw_pkg::OFS_PRIOR1, 32'h0b00abcd);
    rd_chk(rurw_pkg::OFS_PRIOR2, 32'h07123456);
    rd_chk(rurw_pkg::OFS_STATUS, 32'h00000008);
    // three causes at one edge: the pin must win
    boot_done();
    wr(rurw_pkg::OFS_ADDR, 32'h00000777);
    req(1'b1);
    req(1'b0);
    chk({8'h0, boot_address}, 32'h00000777);
    // the user model lags one cycle, so its request is raised first
    want_reconfig <= 1'b1;
    tick(1);
    ext_n <= 1'b0;
    crc_error <= 1'b1;
    tick(1);
    crc_error <= 1'b0;
    tick(4);
    rd_chk(rurw_pkg::OFS_STATUS, 32'h00000040);
    rd_chk(rurw_pkg::OFS_PRIOR1, 32'h42000777);
    chk({8'h0, boot_address}, 32'h00000000);
    // release before factory user mode, or the rise would commit again
    ext_n <= 1'b1;
    want_reconfig <= 1'b0;
    tick(2);
    boot_done();
    stat_n <= 1'b0;
    tick(4);
    stat_n <= 1'b1;
    rd_chk(rurw_pkg::OFS_STATUS, 32'h00000010);
    chk(32'(starts), 32'h00000007);
    finish_test();
  end
endmodule // test_remote_upgrade_reconfig_watchdog
